// [design/msc_mac_stats.sv]
// What this block does
// - Counter read returns count, then clears
// - Counters saturate at all ones
// - Receive counters count only when enabled
// - Counter writes need control bit 7
// - 16-bit good pause frames counter
// - Good frame: valid length, no errors
// - 24-bit successful transmit frames counter
// - 16-bit single collision frames counter
// - 16-bit two-to-fifteen collision counter
// - 24-bit good received copied frames counter
// - 8-bit whole-byte bad CRC counter
// - Symbol error, whole bytes: CRC counter
// - 8-bit alignment error frames counter
// - Symbol error, odd bits: alignment counter
// - 16-bit deferred first-attempt frames counter
// - User I/O bit 0 selects RMII
// - User I/O bit 1 gates transceiver clock
// - 16-bit type ID compared with frames
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
module msc_mac_stats import msc_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire msc_av_req_type avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic rx_done_i,
  input wire msc_rx_status_type rx_st_i,
  input wire logic tx_done_i,
  input wire msc_tx_status_type tx_st_i,
  output logic rmii_mode_o,
  output logic transceiver_clock_gate_o,
  output logic type_match_o
);

  typedef struct packed {
    logic rx_en;
    logic stat_we;
    logic ext_len;
    logic [15:0] type_id;
    logic rmii;
    logic clk_en;
    logic rd_ack;
    logic [31:0] rdata;
    logic type_match;
  } msc_top_state_type;

  localparam logic [3:0] SEL_STAT = OFS_STAT_BASE[5:2];

  msc_top_state_type st_r, st_nxt;
  logic [3:0] sel;
  logic [31:0] rd_mux, be_mask, wval;
  logic rd_take, wr_take;
  logic [STAT_N-1:0] inc, stat_sel, stat_clr, stat_wr;
  logic [31:0] stat_q [STAT_N];

  assign sel = avs_req_i.address[5:2];
  assign rd_take = avs_req_i.read && !st_r.rd_ack;
  assign wr_take = avs_req_i.write;
  assign avs_waitrequest_o = rd_take;
  assign avs_readdata_o = st_r.rdata;
  assign rmii_mode_o = st_r.rmii;
  assign transceiver_clock_gate_o = st_r.clk_en;
  assign type_match_o = st_r.type_match;

  msc_frame_classify u_classify (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .rx_done_i(rx_done_i),
    .rx_st_i(rx_st_i),
    .rx_en_i(st_r.rx_en),
    .ext_len_i(st_r.ext_len),
    .tx_done_i(tx_done_i),
    .tx_st_i(tx_st_i),
    .inc_o(inc)
  );

  for (genvar i = 0; i < STAT_N; i++) begin : g_stat
    logic [STAT_W[i]-1:0] cnt;
    assign stat_sel[i] = sel == SEL_STAT + 4'(i);
    assign stat_clr[i] = rd_take && stat_sel[i];
    assign stat_wr[i] = wr_take && st_r.stat_we && stat_sel[i];
    assign stat_q[i] = {{(32 - STAT_W[i]){1'b0}}, cnt};
    msc_sat_counter #(.W(STAT_W[i])) u_cnt (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .inc_i(inc[i]),
      .clr_i(stat_clr[i]),
      .wr_i(stat_wr[i]),
      .wdata_i(wval[STAT_W[i]-1:0]),
      .cnt_o(cnt)
    );
  end

  // Register readback, zero above each field
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel == OFS_NET_CTRL[5:2]) begin
      rd_mux[NC_RX_EN_BIT] = st_r.rx_en;
      rd_mux[NC_STAT_WE_BIT] = st_r.stat_we;
    end else if (sel == OFS_NET_CFG[5:2]) begin
      rd_mux[CFG_EXT_LEN_BIT] = st_r.ext_len;
    end else if (sel == OFS_TYPE_ID[5:2]) begin
      rd_mux[TID_W-1:0] = st_r.type_id;
    end else if (sel == OFS_USER_IO[5:2]) begin
      rd_mux[UIO_RMII_BIT] = st_r.rmii;
      rd_mux[UIO_TRANSCEIVER_CLOCK_GATE_BIT] = st_r.clk_en;
    end else if (sel >= SEL_STAT && sel < SEL_STAT + 4'(STAT_N)) begin
      rd_mux = stat_q[3'(sel - SEL_STAT)];
    end
  end

  // Byte lanes merged over the current value
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[8*b +: 8] = {8{avs_req_i.byteenable[b]}};
    end
    wval = (rd_mux & ~be_mask) | (avs_req_i.writedata & be_mask);
  end

  always_comb begin
    st_nxt = st_r;
    if (rd_take) begin
      st_nxt.rdata = rd_mux;
      st_nxt.rd_ack = 1'b1;
    end else begin
      st_nxt.rd_ack = 1'b0;
    end
    if (wr_take) begin
      if (sel == OFS_NET_CTRL[5:2]) begin
        st_nxt.rx_en = wval[NC_RX_EN_BIT];
        st_nxt.stat_we = wval[NC_STAT_WE_BIT];
      end else if (sel == OFS_NET_CFG[5:2]) begin
        st_nxt.ext_len = wval[CFG_EXT_LEN_BIT];
      end else if (sel == OFS_TYPE_ID[5:2]) begin
        st_nxt.type_id = wval[TID_W-1:0];
      end else if (sel == OFS_USER_IO[5:2]) begin
        st_nxt.rmii = wval[UIO_RMII_BIT];
        st_nxt.clk_en = wval[UIO_TRANSCEIVER_CLOCK_GATE_BIT];
      end
    end
    if (rx_done_i) begin
      st_nxt.type_match = rx_st_i.type_len == st_r.type_id;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r.rx_en <= RST_RX_EN;
      st_r.stat_we <= RST_STAT_WE;
      st_r.ext_len <= RST_EXT_LEN;
      st_r.type_id <= RST_TYPE_ID;
      st_r.rmii <= RST_RMII;
      st_r.clk_en <= RST_TRANSCEIVER_CLOCK_GATE;
      st_r.rd_ack <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.type_match <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Checks
  logic [STAT_N*32-1:0] stat_flat;
  always_comb begin
    for (int k = 0; k < STAT_N; k++) begin
      stat_flat[32*k +: 32] = stat_q[k];
    end
  end

  read_lat_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (avs_req_i.read && !avs_waitrequest_o) |-> $past(avs_waitrequest_o))
    else $error("read answered without wait cycle");
  write_nowait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    avs_req_i.write |-> !avs_waitrequest_o)
    else $error("write stalled");
  rd_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_take && stat_sel[IDX_CRC] && !inc[IDX_CRC])
    |=> stat_q[IDX_CRC] == 32'h0 && avs_readdata_o == $past(stat_q[IDX_CRC]))
    else $error("read did not return and clear");
  wr_block_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_take && !st_r.stat_we && inc == '0 && !avs_req_i.read) |=> $stable(stat_flat))
    else $error("counter written while locked");
  wr_take_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (stat_wr[IDX_DEFER] && avs_req_i.byteenable == 4'hf && !inc[IDX_DEFER])
    |=> stat_q[IDX_DEFER] == {16'h0000, $past(avs_req_i.writedata[15:0])})
    else $error("counter write lost");
  rmii_sel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_take && sel == OFS_USER_IO[5:2] && avs_req_i.byteenable[0])
    |=> rmii_mode_o == $past(avs_req_i.writedata[UIO_RMII_BIT]))
    else $error("mode select not applied");
  clk_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_take && sel == OFS_USER_IO[5:2] && avs_req_i.byteenable[0])
    |=> transceiver_clock_gate_o == $past(avs_req_i.writedata[UIO_TRANSCEIVER_CLOCK_GATE_BIT]))
    else $error("clock gate not applied");
  type_cmp_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_done_i |=> type_match_o == ($past(rx_st_i.type_len) == $past(st_r.type_id)))
    else $error("type compare wrong");
  upper_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (avs_req_i.read && !avs_waitrequest_o && $past(sel) == OFS_TYPE_ID[5:2]
     && $past(rd_take)) |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("reserved bits not zero");

  read_cnt_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    rd_take && stat_sel[IDX_RX_OK] && stat_q[IDX_RX_OK] != 32'h0);
  sat_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    stat_q[IDX_CRC] == 32'h0000_00ff && inc[IDX_CRC]);
  wr_cnt_c: cover property (@(posedge clk_i) disable iff (!resetn_i) |stat_wr);
  rmii_c: cover property (@(posedge clk_i) disable iff (!resetn_i) rmii_mode_o);

endmodule // msc_mac_stats

// [design/msc_pkg.sv]
package msc_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int LEN_W = 14;
  localparam int STAT_N = 8;

  // Byte offsets
  localparam logic [5:0] OFS_NET_CTRL = 6'h00;
  localparam logic [5:0] OFS_NET_CFG = 6'h04;
  localparam logic [5:0] OFS_TYPE_ID = 6'h08;
  localparam logic [5:0] OFS_USER_IO = 6'h0c;
  localparam logic [5:0] OFS_STAT_BASE = 6'h10;

  // Field positions
  localparam int NC_RX_EN_BIT = 2;
  localparam int NC_STAT_WE_BIT = 7;
  localparam int CFG_EXT_LEN_BIT = 8;
  localparam int UIO_RMII_BIT = 0;
  localparam int UIO_TRANSCEIVER_CLOCK_GATE_BIT = 1;
  localparam int TID_W = 16;

  // Reset values
  localparam logic RST_RX_EN = 1'b0;
  localparam logic RST_STAT_WE = 1'b0;
  localparam logic RST_EXT_LEN = 1'b0;
  localparam logic RST_RMII = 1'b0;
  localparam logic RST_TRANSCEIVER_CLOCK_GATE = 1'b0;
  localparam logic [15:0] RST_TYPE_ID = 16'h0000;

  // Frame length limits in bytes
  localparam logic [13:0] FRAME_MIN = 14'd64;
  localparam logic [13:0] FRAME_MAX = 14'd1518;
  localparam logic [13:0] FRAME_MAX_EXT = 14'd1536;

  // Counter slots, in address order
  localparam int IDX_PAUSE = 0;
  localparam int IDX_TX_OK = 1;
  localparam int IDX_ONE_COL = 2;
  localparam int IDX_MULTI_COL = 3;
  localparam int IDX_RX_OK = 4;
  localparam int IDX_CRC = 5;
  localparam int IDX_ALIGN = 6;
  localparam int IDX_DEFER = 7;
  localparam int STAT_W [STAT_N] = '{16, 24, 16, 16, 24, 8, 8, 16};

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } msc_av_req_type;

  typedef struct packed {
    logic [13:0] len;
    logic dribble;
    logic crc_bad;
    logic sym_err;
    logic pause;
    logic addr_match;
    logic copied;
    logic [15:0] type_len;
  } msc_rx_status_type;

  typedef struct packed {
    logic underrun;
    logic retry_exceeded;
    logic [4:0] coll_cnt;
    logic deferred;
  } msc_tx_status_type;

endpackage

// [design/msc_sat_counter.sv]
`timescale 1ns/10ps
module msc_sat_counter import msc_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic inc_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] cnt_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } msc_cnt_state_type;

  msc_cnt_state_type st_r, st_nxt;
  logic [W-1:0] base;

  always_comb begin
    base = st_r.cnt;
    if (wr_i) begin
      base = wdata_i;
    end else if (clr_i) begin
      base = '0;
    end
    st_nxt.cnt = base;
    if (inc_i && base != {W{1'b1}}) begin
      st_nxt.cnt = base + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt_o = st_r.cnt;

  sat_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (cnt_o == {W{1'b1}} && inc_i && !clr_i && !wr_i) |=> cnt_o == {W{1'b1}})
    else $error("counter wrapped");
  inc_step_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (inc_i && !clr_i && !wr_i && cnt_o != {W{1'b1}}) |=> cnt_o == $past(cnt_o) + W'(1))
    else $error("counter missed increment");
  clr_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (clr_i && !wr_i) |=> cnt_o == (W'($past(inc_i))))
    else $error("counter not cleared");

endmodule // msc_sat_counter

// [design/msc_frame_classify.sv]
`timescale 1ns/10ps
module msc_frame_classify import msc_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic rx_done_i,
  input wire msc_rx_status_type rx_st_i,
  input wire logic rx_en_i,
  input wire logic ext_len_i,
  input wire logic tx_done_i,
  input wire msc_tx_status_type tx_st_i,
  output logic [STAT_N-1:0] inc_o
);

  typedef struct packed {
    logic [STAT_N-1:0] inc;
  } msc_cls_state_type;

  msc_cls_state_type st_r, st_nxt;
  logic [13:0] max_len;
  logic len_ok, rx_go, good, bad_fcs, tx_ok;

  always_comb begin
    max_len = ext_len_i ? FRAME_MAX_EXT : FRAME_MAX;
    len_ok = rx_st_i.len >= FRAME_MIN && rx_st_i.len <= max_len;
    rx_go = rx_done_i && rx_en_i;
    good = len_ok && !rx_st_i.crc_bad && !rx_st_i.dribble && !rx_st_i.sym_err;
    bad_fcs = rx_st_i.crc_bad || rx_st_i.sym_err;
    tx_ok = tx_done_i && !tx_st_i.underrun && !tx_st_i.retry_exceeded;
    st_nxt.inc = '0;
    st_nxt.inc[IDX_PAUSE] = rx_go && good && rx_st_i.pause;
    st_nxt.inc[IDX_TX_OK] = tx_ok;
    st_nxt.inc[IDX_ONE_COL] = tx_ok && tx_st_i.coll_cnt == 5'h01;
    st_nxt.inc[IDX_MULTI_COL] = tx_ok && tx_st_i.coll_cnt >= 5'h02
      && tx_st_i.coll_cnt <= 5'h0f;
    st_nxt.inc[IDX_RX_OK] = rx_go && good && rx_st_i.addr_match && rx_st_i.copied;
    st_nxt.inc[IDX_CRC] = rx_go && len_ok && !rx_st_i.dribble && bad_fcs;
    st_nxt.inc[IDX_ALIGN] = rx_go && len_ok && rx_st_i.dribble && bad_fcs;
    st_nxt.inc[IDX_DEFER] = tx_done_i && tx_st_i.deferred && tx_st_i.coll_cnt == 5'h00
      && !tx_st_i.underrun;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign inc_o = st_r.inc;

  rx_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!rx_en_i) |=> (inc_o[IDX_PAUSE] | inc_o[IDX_RX_OK] | inc_o[IDX_CRC] | inc_o[IDX_ALIGN]) == 1'b0)
    else $error("rx counted while disabled");
  pause_good_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rx_done_i && rx_en_i && rx_st_i.pause && rx_st_i.len == FRAME_MIN && !rx_st_i.crc_bad
     && !rx_st_i.dribble && !rx_st_i.sym_err) |=> inc_o[IDX_PAUSE])
    else $error("good pause not counted");
  long_frame_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rx_done_i && rx_st_i.len > FRAME_MAX_EXT) |=> !inc_o[IDX_RX_OK] && !inc_o[IDX_CRC])
    else $error("oversize frame counted");
  tx_col_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    inc_o[IDX_ONE_COL] |-> inc_o[IDX_TX_OK] && !inc_o[IDX_MULTI_COL] && !inc_o[IDX_DEFER])
    else $error("collision classes overlap");
  err_split_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rx_done_i && rx_en_i && rx_st_i.sym_err && rx_st_i.dribble && rx_st_i.len == FRAME_MAX)
    |=> inc_o[IDX_ALIGN] && !inc_o[IDX_CRC])
    else $error("symbol error misfiled");

endmodule // msc_frame_classify

// [sim/msc_phy_model.sv]
`timescale 1ns/10ps
module msc_phy_model import msc_pkg::*; (
  input wire logic clk_i,
  output logic rx_done_o,
  output msc_rx_status_type rx_st_o,
  output logic tx_done_o,
  output msc_tx_status_type tx_st_o
);
  initial begin
    rx_done_o = 1'b0;
    rx_st_o = '1;
    tx_done_o = 1'b0;
    tx_st_o = '1;
  end

  // Status valid with its pulse only, scrambled afterwards
  task automatic send_rx(input msc_rx_status_type st);
    @(posedge clk_i);
    rx_done_o <= 1'b1;
    rx_st_o <= st;
    @(posedge clk_i);
    rx_done_o <= 1'b0;
    rx_st_o <= ~st;
  endtask

  task automatic send_tx(input msc_tx_status_type st);
    @(posedge clk_i);
    tx_done_o <= 1'b1;
    tx_st_o <= st;
    @(posedge clk_i);
    tx_done_o <= 1'b0;
    tx_st_o <= ~st;
  endtask
endmodule // msc_phy_model

// [sim/msc_mac_stats_tb_top.sv]
`timescale 1ns/10ps
module msc_mac_stats_tb_top import msc_pkg::*; ;
  logic clk_i;
  logic resetn_i;
  msc_av_req_type avs_req;
  logic [31:0] rdata;
  logic wait_req;
  logic rx_done;
  msc_rx_status_type rx_st;
  logic tx_done;
  msc_tx_status_type tx_st;
  logic rmii;
  logic gate;
  logic tmatch;
  int n_mismatch = 0;
  int checked = 0;

  msc_mac_stats i_msc_mac_stats (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .avs_req_i(avs_req),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req),
    .rx_done_i(rx_done),
    .rx_st_i(rx_st),
    .tx_done_i(tx_done),
    .tx_st_i(tx_st),
    .rmii_mode_o(rmii),
    .transceiver_clock_gate_o(gate),
    .type_match_o(tmatch)
  );

  msc_phy_model i_msc_phy_model (
    .clk_i(clk_i),
    .rx_done_o(rx_done),
    .rx_st_o(rx_st),
    .tx_done_o(tx_done),
    .tx_st_o(tx_st)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is low at a rising edge
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_req <= '{read: rd, write: !rd, address: a, writedata: wd, byteenable: 4'hf};
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    if (wait_req !== 1'b0) n_mismatch++;
    rv = rdata;
    avs_req <= '0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b0, a, d, x);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b1, a, 32'h0000_0000, x);
    check(x, e);
  endtask

  function automatic logic [5:0] ca(input int i);
    return OFS_STAT_BASE + 6'(4 * i);
  endfunction

  // Flags: dribble crc sym pause match copied
  task automatic rx(input logic [13:0] len, input logic [5:0] f, input logic [15:0] tl);
    i_msc_phy_model.send_rx({len, f, tl});
  endtask

  // Bits: underrun retry coll[4:0] deferred
  task automatic tx(input logic [7:0] v);
    i_msc_phy_model.send_tx(v);
  endtask

  task automatic t_reset();
    for (int i = 0; i < STAT_N; i++) rd(ca(i), 32'h0000_0000);
    rd(OFS_TYPE_ID, 32'h0000_0000);
    rd(6'h3c, 32'h0000_0000);
  endtask

  task automatic t_uio();
    wr(OFS_USER_IO, 32'hffff_ffff);
    rd(OFS_USER_IO, 32'h0000_0003);
    check({31'h0, rmii}, 32'h1);
    check({31'h0, gate}, 32'h1);
    wr(OFS_USER_IO, 32'h0000_0001);
    @(negedge clk_i);
    check({31'h0, gate}, 32'h0);
    wr(OFS_USER_IO, 32'h0000_0002);
    @(negedge clk_i);
    check({30'h0, gate, rmii}, 32'h2);
  endtask

  task automatic t_gate();
    rx(14'd64, 6'h03, 16'h0000);
    rd(ca(IDX_RX_OK), 32'h0000_0000);
    wr(OFS_NET_CTRL, 32'h0000_0004);
    rx(14'd64, 6'h03, 16'h0000);
    rd(ca(IDX_RX_OK), 32'h0000_0001);
    rd(ca(IDX_RX_OK), 32'h0000_0000);
  endtask

  task automatic t_type();
    wr(OFS_TYPE_ID, 32'hffff_a5c3);
    rd(OFS_TYPE_ID, 32'h0000_a5c3);
    rx(14'd64, 6'h03, 16'ha5c3);
    @(negedge clk_i);
    check({31'h0, tmatch}, 32'h1);
    rx(14'd64, 6'h03, 16'ha5c2);
    @(negedge clk_i);
    check({31'h0, tmatch}, 32'h0);
    rd(ca(IDX_RX_OK), 32'h0000_0002);
  endtask

  task automatic t_rx();
    rx(14'd64, 6'h07, 16'h0000);
    rx(14'd1518, 6'h03, 16'h0000);
    rx(14'd1519, 6'h03, 16'h0000);
    rx(14'd63, 6'h07, 16'h0000);
    rx(14'd200, 6'h02, 16'h0000);
    rx(14'd100, 6'h10, 16'h0000);
    rx(14'd100, 6'h08, 16'h0000);
    rx(14'd100, 6'h30, 16'h0000);
    rx(14'd100, 6'h28, 16'h0000);
    rx(14'd1600, 6'h10, 16'h0000);
    wr(OFS_NET_CFG, 32'h0000_0100);
    rx(14'd1536, 6'h03, 16'h0000);
    rx(14'd1537, 6'h10, 16'h0000);
    wr(OFS_NET_CFG, 32'h0000_0000);
    rd(ca(IDX_PAUSE), 32'h0000_0001);
    rd(ca(IDX_RX_OK), 32'h0000_0003);
    rd(ca(IDX_CRC), 32'h0000_0002);
    rd(ca(IDX_ALIGN), 32'h0000_0002);
  endtask

  task automatic t_tx();
    logic [7:0] v [8] = '{8'h00, 8'h02, 8'h04, 8'h1e, 8'h01, 8'h03, 8'h82, 8'h60};
    wr(OFS_NET_CTRL, 32'h0000_0000);
    foreach (v[i]) tx(v[i]);
    rd(ca(IDX_TX_OK), 32'h0000_0006);
    rd(ca(IDX_ONE_COL), 32'h0000_0002);
    rd(ca(IDX_MULTI_COL), 32'h0000_0002);
    rd(ca(IDX_DEFER), 32'h0000_0001);
  endtask

  task automatic t_write();
    wr(ca(IDX_CRC), 32'h0000_0012);
    rd(ca(IDX_CRC), 32'h0000_0000);
    wr(OFS_NET_CTRL, 32'h0000_0084);
    wr(ca(IDX_CRC), 32'hffff_fff0);
    rd(ca(IDX_CRC), 32'h0000_00f0);
    wr(ca(IDX_CRC), 32'h0000_00fe);
    rx(14'd100, 6'h10, 16'h0000);
    rx(14'd100, 6'h10, 16'h0000);
    rd(ca(IDX_CRC), 32'h0000_00ff);
    rd(ca(IDX_CRC), 32'h0000_0000);
    wr(ca(IDX_TX_OK), 32'h00ff_fffe);
    tx(8'h00);
    tx(8'h00);
    rd(ca(IDX_TX_OK), 32'h00ff_ffff);
  endtask

  initial begin
    resetn_i = 1'b0;
    avs_req = '0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_uio();
    t_gate();
    t_type();
    t_rx();
    t_tx();
    t_write();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end
endmodule // msc_mac_stats_tb_top
